// *** pio_port.sv ***
// The placing of the registers and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
`include "pio_regs.svh"
module pio_port import pio_pkg::*; #(
    parameter int NUM_PINS = `PIO_NUM_PINS
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic [8:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic [NUM_PINS-1:0] pin_i,
    output logic [NUM_PINS-1:0] pin_o,
    output logic [NUM_PINS-1:0] pin_oe_o,
    output logic [NUM_PINS-1:0] pullup_o,
    output logic [NUM_PINS-1:0] slew_limit_o,
    output logic [NUM_PINS-1:0] high_drive_o,
    input wire logic [NUM_PINS-1:0] periph_en_i,
    input wire logic [NUM_PINS-1:0] periph_oe_i,
    input wire logic [NUM_PINS-1:0] periph_do_i,
    input wire logic [NUM_PINS-1:0] analog_en_i,
    input wire logic in_only_pin_i,
    output logic [1:0] out_only_pin_o,
    input wire logic partial_powerdown_stop_i
);
    localparam int NP = (NUM_PINS + 7) / 8;
    localparam int NW = NP * `PIO_PORT_W;

    if (NUM_PINS < 1 || NUM_PINS > 64) begin : g_bad_pins
        $error("pio_port: NUM_PINS must be 1..64");
    end

    typedef struct packed {
        logic [NW-1:0] latch;
        logic [NW-1:0] dir;
        logic [NW-1:0] pull;
        logic [NW-1:0] slew;
        logic [NW-1:0] drive;
        logic [NUM_PINS-1:0] out;
        logic [NUM_PINS-1:0] oe;
        logic [NUM_PINS-1:0] pu;
        logic [NUM_PINS-1:0] sl;
        logic [NUM_PINS-1:0] hd;
        logic [1:0] oonly;
        logic ppd_prev;
        logic ppd_flag;
    } pio_core_st_t;

    pio_core_st_t st_r;
    pio_core_st_t st_nxt;

    pio_bus_if bus ();

    logic [NUM_PINS:0] sync_q;
    logic [NW-1:0] pin_w;
    logic [NW-1:0] ana_w;
    logic [NW-1:0] impl_w;
    logic [NUM_PINS-1:0] oe_w;
    logic [NUM_PINS-1:0] out_w;
    logic [NUM_PINS-1:0] pu_w;
    logic [NUM_PINS-1:0] sl_w;
    logic [NUM_PINS-1:0] hd_w;
    logic [2:0] port_idx;
    logic port_hit;
    logic ppd_fall;
    logic ack_wr;

    pio_avalon_slave u_slave (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o),
        .bus(bus.slave)
    );

    pio_sync #(.W(NUM_PINS + 1)) u_sync (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .d_i({in_only_pin_i, pin_i}),
        .q_o(sync_q)
    );

    // Pads past the last pin read as zero and drive nothing
    always_comb begin
        pin_w = '0;
        ana_w = '0;
        impl_w = '0;
        pin_w[NUM_PINS-1:0] = sync_q[NUM_PINS-1:0];
        ana_w[NUM_PINS-1:0] = analog_en_i;
        impl_w[NUM_PINS-1:0] = '1;
    end

    for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
        logic dig;
        // Analog outranks the digital peripheral
        assign dig = periph_en_i[i] & ~analog_en_i[i];
        always_comb begin
            if (analog_en_i[i]) begin
                oe_w[i] = 1'b0;
                out_w[i] = 1'b0;
            end else if (dig) begin
                oe_w[i] = periph_oe_i[i];
                out_w[i] = periph_do_i[i];
            end else begin
                oe_w[i] = st_r.dir[i];
                out_w[i] = st_r.latch[i];
            end
        end
        // Pull-up sees both the port's and the peripheral's direction
        assign pu_w[i] = st_r.pull[i] & ~analog_en_i[i] & ~oe_w[i] & ~st_r.dir[i];
        assign sl_w[i] = st_r.slew[i] & oe_w[i];
        assign hd_w[i] = st_r.drive[i] & ~analog_en_i[i];
    end

    assign port_idx = bus.addr[7:5];
    assign port_hit = !bus.addr[`PIO_HIGH_PAGE_BIT] && ({1'b0, port_idx} < 4'(NP));
    assign ppd_fall = st_r.ppd_prev && !partial_powerdown_stop_i;
    assign ack_wr = bus.wr_stb && (bus.addr == `PIO_ADDR_PWR) && bus.wdata[`PIO_ACK_BIT];

    // Read source follows direction even under a peripheral
    always_comb begin
        logic [7:0] d;
        logic [7:0] m;
        logic [7:0] a;
        d = st_r.dir[port_idx * 8 +: 8];
        m = impl_w[port_idx * 8 +: 8];
        a = ana_w[port_idx * 8 +: 8];
        bus.rdata = 8'h00;
        if (port_hit) begin
            unique case (bus.addr[4:0])
                `PIO_OFF_DATA: bus.rdata = m & ~a & ((d & st_r.latch[port_idx * 8 +: 8]) |
                    (~d & pin_w[port_idx * 8 +: 8]));
                `PIO_OFF_DIR: bus.rdata = m & d;
                `PIO_OFF_PULL: bus.rdata = m & st_r.pull[port_idx * 8 +: 8];
                `PIO_OFF_SLEW: bus.rdata = m & st_r.slew[port_idx * 8 +: 8];
                `PIO_OFF_DRIVE: bus.rdata = m & st_r.drive[port_idx * 8 +: 8];
                default: bus.rdata = 8'h00;
            endcase
        end else if (bus.addr == `PIO_ADDR_PWR) begin
            bus.rdata[`PIO_FLAG_BIT] = st_r.ppd_flag;
        end else if (bus.addr == `PIO_ADDR_AUX) begin
            bus.rdata[1:0] = st_r.oonly;
            bus.rdata[`PIO_IN_ONLY_BIT] = sync_q[NUM_PINS];
        end
    end

    always_comb begin
        st_nxt = st_r;
        if (bus.wr_stb && port_hit) begin
            unique case (bus.addr[4:0])
                `PIO_OFF_DATA: st_nxt.latch[port_idx * 8 +: 8] = bus.wdata;
                `PIO_OFF_DIR: st_nxt.dir[port_idx * 8 +: 8] = bus.wdata;
                // Pin controls touch nothing else
                `PIO_OFF_PULL: st_nxt.pull[port_idx * 8 +: 8] = bus.wdata;
                `PIO_OFF_SLEW: st_nxt.slew[port_idx * 8 +: 8] = bus.wdata;
                `PIO_OFF_DRIVE: st_nxt.drive[port_idx * 8 +: 8] = bus.wdata;
                default: st_nxt.latch = st_r.latch;
            endcase
        end
        if (bus.wr_stb && bus.addr == `PIO_ADDR_AUX) begin
            st_nxt.oonly = bus.wdata[1:0];
        end
        // Pin stage freezes while the core is powered down
        if (!partial_powerdown_stop_i) begin
            st_nxt.out = out_w;
            st_nxt.oe = oe_w;
            st_nxt.pu = pu_w;
            st_nxt.sl = sl_w;
            st_nxt.hd = hd_w;
        end
        st_nxt.ppd_prev = partial_powerdown_stop_i;
        // Set wins over a same-cycle acknowledge
        if (ppd_fall) begin
            st_nxt.ppd_flag = 1'b1;
        end else if (ack_wr) begin
            st_nxt.ppd_flag = 1'b0;
        end
    end

    // Stop does not gate the clock: registers still take writes, and only the pin stage holds
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            st_r.latch <= {NP{`PIO_RST_LATCH}};
            st_r.dir <= {NP{`PIO_RST_DIR}};
            st_r.pull <= {NP{`PIO_RST_PULL}};
            st_r.slew <= {NP{`PIO_RST_SLEW}};
            st_r.drive <= {NP{`PIO_RST_DRIVE}};
            st_r.out <= '0;
            st_r.oe <= '0;
            st_r.pu <= '0;
            st_r.sl <= '0;
            st_r.hd <= '0;
            st_r.oonly <= 2'h0;
            st_r.ppd_prev <= 1'b0;
            st_r.ppd_flag <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pin_o = st_r.out;
    assign pin_oe_o = st_r.oe;
    assign pullup_o = st_r.pu;
    assign slew_limit_o = st_r.sl;
    assign high_drive_o = st_r.hd;
    assign out_only_pin_o = st_r.oonly;

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rstn_i);

    sequence s_stop_held;
        partial_powerdown_stop_i ##1 partial_powerdown_stop_i;
    endsequence

    sequence s_data_write;
        bus.wr_stb && port_hit && bus.addr[4:0] == `PIO_OFF_DATA;
    endsequence

    a_reset_inputs: assert property ($past(!rstn_i) |-> pin_oe_o == '0 && pullup_o == '0)
        else $error("pins not inputs after reset");

    a_reset_slew: assert property ($past(!rstn_i) |-> st_r.slew == {NP{`PIO_RST_SLEW}})
        else $error("slew bits wrong after reset");

    a_gpio_oe_dir: assert property (!partial_powerdown_stop_i |=>
        ((pin_oe_o ^ $past(st_r.dir[NUM_PINS-1:0])) &
        ~$past(periph_en_i | analog_en_i)) == '0)
        else $error("driver enable does not follow direction");

    a_periph_owns: assert property (!partial_powerdown_stop_i |=>
        ((pin_o ^ $past(periph_do_i)) & $past(periph_en_i & ~analog_en_i)) == '0)
        else $error("peripheral did not take the pin");

    a_analog_wins: assert property (!partial_powerdown_stop_i |=>
        (pin_oe_o & $past(analog_en_i)) == '0)
        else $error("analog pin still driven");

    a_analog_no_pull: assert property (!partial_powerdown_stop_i |=>
        (pullup_o & $past(analog_en_i)) == '0)
        else $error("pull-up on analog pin");

    a_pull_not_out: assert property ((pullup_o & pin_oe_o) == '0)
        else $error("pull-up on output pin");

    a_pull_dir_out: assert property (!partial_powerdown_stop_i |=>
        (pullup_o & $past(st_r.dir[NUM_PINS-1:0])) == '0)
        else $error("pull-up on pin set as port output");

    a_slew_outputs: assert property ((slew_limit_o & ~pin_oe_o) == '0)
        else $error("slew limit on input pin");

    a_stop_hold: assert property (s_stop_held |-> $stable(pin_o) && $stable(pin_oe_o))
        else $error("pins changed during partial power-down");

    a_latch_write: assert property (s_data_write |=>
        st_r.latch[$past(port_idx) * 8 +: 8] == $past(bus.wdata))
        else $error("data write not latched");

    a_flag_set: assert property ($fell(partial_powerdown_stop_i) |-> ##1 st_r.ppd_flag)
        else $error("recovery flag not set");

    a_flag_ack: assert property (ack_wr && !ppd_fall |=> !st_r.ppd_flag)
        else $error("acknowledge did not clear flag");

    a_read_analog: assert property (port_hit && bus.addr[4:0] == `PIO_OFF_DATA |->
        (bus.rdata & ana_w[port_idx * 8 +: 8]) == 8'h00)
        else $error("analog bit read non-zero");

endmodule

// *** pio_regs.svh ***
`ifndef PIO_REGS_SVH
`define PIO_REGS_SVH
`define PIO_NUM_PINS 49
`define PIO_PORT_W 8
`define PIO_PORT_LSB 5
`define PIO_OFF_DATA 5'h00
`define PIO_OFF_DIR 5'h04
`define PIO_OFF_PULL 5'h08
`define PIO_OFF_SLEW 5'h0C
`define PIO_OFF_DRIVE 5'h10
`define PIO_ADDR_PWR 9'h100
`define PIO_ADDR_AUX 9'h104
`define PIO_HIGH_PAGE_BIT 8
`define PIO_FLAG_BIT 3
`define PIO_ACK_BIT 2
`define PIO_IN_ONLY_BIT 2
`define PIO_RST_LATCH 8'h00
`define PIO_RST_DIR 8'h00
`define PIO_RST_PULL 8'h00
`define PIO_RST_SLEW 8'hFF
`define PIO_RST_DRIVE 8'h00
`endif

// *** pio_pkg.sv ***
package pio_pkg;
    typedef enum logic {
        PIO_IDLE,
        PIO_ANSWER
    } pio_bus_state_t;
    typedef struct packed {
        pio_bus_state_t state;
        logic [31:0] rdata;
    } pio_slave_st_t;
endpackage

// *** pio_bus_if.sv ***
`timescale 1ns/1ps
interface pio_bus_if;
    logic wr_stb;
    logic [8:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport slave (output wr_stb, output addr, output wdata, input rdata);
    modport core (input wr_stb, input addr, input wdata, output rdata);
endinterface

// *** pio_sync.sv ***
`timescale 1ns/1ps
module pio_sync import pio_pkg::*; #(
    parameter int W = 50
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } pio_sync_st_t;
    pio_sync_st_t st_r;
    pio_sync_st_t st_nxt;
    if (W < 1) begin : g_bad_width
        $error("pio_sync: width must be positive");
    end
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = d_i;
        st_nxt.s2 = st_r.s1;
    end
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    // Only the second stage leaves the module
    assign q_o = st_r.s2;
endmodule

// *** pio_avalon_slave.sv ***
`timescale 1ns/1ps
module pio_avalon_slave import pio_pkg::*; (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic [8:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    pio_bus_if.slave bus
);
    pio_slave_st_t st_r;
    pio_slave_st_t st_nxt;
    logic req;
    assign req = avs_read_i | avs_write_i;
    // One wait cycle gives the read mux a full cycle
    assign avs_waitrequest_o = req && (st_r.state == PIO_IDLE);
    assign avs_readdata_o = st_r.rdata;
    assign bus.addr = avs_address_i;
    assign bus.wdata = avs_writedata_i[7:0];
    assign bus.wr_stb = avs_write_i && avs_byteenable_i[0] && (st_r.state == PIO_ANSWER);
    always_comb begin
        st_nxt = st_r;
        unique case (st_r.state)
            PIO_IDLE: begin
                if (req) begin
                    st_nxt.state = PIO_ANSWER;
                    st_nxt.rdata = {24'h000000, bus.rdata};
                end
            end
            PIO_ANSWER: begin
                st_nxt.state = PIO_IDLE;
            end
        endcase
    end
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            st_r <= '{state: PIO_IDLE, rdata: 32'h00000000};
        end else begin
            st_r <= st_nxt;
        end
    end
    a_wait_bounded: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        req |-> ##[0:1] !avs_waitrequest_o) else $error("waitrequest held too long");
endmodule

// *** pio_board_model.sv ***
`timescale 1ns/1ps
module pio_board_model #(
    parameter int N = 49
) (
    input wire logic sys_clk_i,
    input wire logic [N-1:0] drv_val_i,
    input wire logic [N-1:0] drv_en_i,
    input wire logic [N-1:0] pull_i,
    input wire logic [N-1:0] ext_en_i,
    input wire logic [N-1:0] ext_val_i,
    output logic [N-1:0] level_o
);
    logic [N-1:0] float_r = '0;
    // Floating lines wander, so no stale level can pass for a match
    always @(posedge sys_clk_i) begin
        float_r <= ~float_r;
    end
    // Chip driver first, then board driver, then pull-up, else floating
    assign level_o = (drv_en_i & drv_val_i) | (~drv_en_i & ext_en_i & ext_val_i)
        | (~drv_en_i & ~ext_en_i & (pull_i | float_r));
endmodule

// *** parallel_io_port_with_pin_control_test.sv ***
`timescale 1ns/1ps
`include "pio_regs.svh"
module parallel_io_port_with_pin_control_test;
    logic sys_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [8:0] avs_address_i = '0;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = '0;
    logic [3:0] avs_byteenable_i = 4'hF;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic [48:0] pin_level, pin_o, pin_oe_o, pullup_o, slew_limit_o, high_drive_o;
    logic [48:0] periph_en = '0, periph_oe = '0, periph_do = '0, analog_en = '0;
    logic [48:0] ext_en = '0, ext_val = '0;
    logic in_only = 1'b1;
    logic stop = 1'b0;
    logic [1:0] out_only_pin_o;
    logic [31:0] exp_q[$];
    logic [7:0] v;
    int bad_count = 0;
    int tests_run = 0;

    always #2 sys_clk_i = ~sys_clk_i;

    pio_port #(.NUM_PINS(49)) i_dut (
        .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .pin_i(pin_level), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pullup_o(pullup_o),
        .slew_limit_o(slew_limit_o), .high_drive_o(high_drive_o),
        .periph_en_i(periph_en), .periph_oe_i(periph_oe), .periph_do_i(periph_do),
        .analog_en_i(analog_en), .in_only_pin_i(in_only), .out_only_pin_o(out_only_pin_o),
        .partial_powerdown_stop_i(stop)
    );

    pio_board_model #(.N(49)) i_board (
        .sys_clk_i(sys_clk_i), .drv_val_i(pin_o), .drv_en_i(pin_oe_o), .pull_i(pullup_o),
        .ext_en_i(ext_en), .ext_val_i(ext_val), .level_o(pin_level)
    );

    function automatic logic [8:0] ra(input int p, input logic [4:0] off);
        return 9'(p * 32) | {4'h0, off};
    endfunction

    task automatic close_out();
        if (exp_q.size() != 0) begin
            bad_count++;
        end
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t read %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_pin(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t pins %h expected %h", $time, got, exp);
        end
    endtask

    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [8:0] a, input logic [7:0] d,
            input logic [3:0] be);
        @(posedge sys_clk_i);
        avs_address_i <= a;
        avs_write_i <= wr;
        avs_read_i <= ~wr;
        avs_writedata_i <= {24'h0, d};
        avs_byteenable_i <= be;
        do begin
            @(posedge sys_clk_i);
        end while (avs_waitrequest_o !== 1'b0);
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 4'hF);
    endtask

    task automatic rd(input logic [8:0] a, input logic [7:0] e);
        exp_q.push_back({24'h0, e});
        bus(1'b0, a, 8'h00, 4'hF);
    endtask

    // Pins follow registers one edge later
    task automatic look();
        repeat (2) @(negedge sys_clk_i);
    endtask

    always @(posedge sys_clk_i) begin
        if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0) begin
            cmp_rd(avs_readdata_o, exp_q.pop_front());
        end
    end

    initial begin
        repeat (20000) @(posedge sys_clk_i);
        bad_count++;
        $display("CHECK FAILED %0t watchdog expired", $time);
        close_out();
    end

    initial begin
        void'($urandom(32'h2EE0B76C));
        repeat (8) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        look();
        cmp_pin(pin_oe_o, 64'h0);
        cmp_pin(pullup_o, 64'h0);
        cmp_pin(slew_limit_o, 64'h0);
        cmp_pin(high_drive_o, 64'h0);
        rd(ra(0, `PIO_OFF_DIR), `PIO_RST_DIR);
        rd(ra(0, `PIO_OFF_PULL), `PIO_RST_PULL);
        rd(ra(0, `PIO_OFF_SLEW), `PIO_RST_SLEW);
        rd(ra(0, `PIO_OFF_DRIVE), `PIO_RST_DRIVE);
        rd(`PIO_ADDR_PWR, 8'h00);
        wr(ra(1, `PIO_OFF_DIR), 8'hFF);
        rd(ra(1, `PIO_OFF_DATA), `PIO_RST_LATCH);
        look();
        cmp_pin(pin_o[15:8], 64'h0);
        cmp_pin(pin_oe_o[15:8], 64'hFF);
        $display("test reset done");
        @(posedge sys_clk_i);
        ext_en <= 49'hFF;
        ext_val <= 49'hBC;
        analog_en <= 49'h50;
        // Pin 2: peripheral owns it as input while the port direction says output
        periph_en <= 49'h64;
        periph_oe <= 49'h60;
        periph_do <= 49'h40;
        wr(ra(0, `PIO_OFF_DATA), 8'hA5);
        wr(ra(0, `PIO_OFF_PULL), 8'hFF);
        wr(ra(0, `PIO_OFF_DIR), 8'h0F);
        wr(ra(0, `PIO_OFF_DRIVE), 8'h5A);
        rd(ra(0, `PIO_OFF_DATA), 8'h85);
        rd(ra(0, `PIO_OFF_DIR), 8'h0F);
        look();
        cmp_pin(pin_oe_o[7:0], 64'h2B);
        cmp_pin({pin_o[5], pin_o[3:0]}, 64'h01);
        cmp_pin(pullup_o[7:0], 64'h80);
        cmp_pin(slew_limit_o[7:0], 64'h2B);
        cmp_pin(high_drive_o[7:0], 64'h0A);
        $display("test sharing done");
        @(posedge sys_clk_i);
        stop <= 1'b1;
        wr(ra(1, `PIO_OFF_DATA), 8'h99);
        rd(ra(1, `PIO_OFF_DATA), 8'h99);
        look();
        cmp_pin(pin_o[15:8], 64'h0);
        @(posedge sys_clk_i);
        stop <= 1'b0;
        rd(`PIO_ADDR_PWR, 8'h08);
        look();
        cmp_pin(pin_o[15:8], 64'h99);
        wr(`PIO_ADDR_PWR, 8'h04);
        rd(`PIO_ADDR_PWR, 8'h00);
        $display("test powerdown done");
        for (int p = 2; p < 6; p++) begin
            v = 8'($urandom());
            wr(ra(p, `PIO_OFF_DATA), v);
            wr(ra(p, `PIO_OFF_DIR), 8'hFF);
            rd(ra(p, `PIO_OFF_DATA), v);
            look();
            cmp_pin(pin_o[p*8+:8], {56'h0, v});
        end
        // Low byte lane off: the write must be dropped
        bus(1'b1, ra(5, `PIO_OFF_DATA), ~v, 4'hE);
        rd(ra(5, `PIO_OFF_DATA), v);
        wr(ra(6, `PIO_OFF_DATA), 8'hFF);
        wr(ra(6, `PIO_OFF_DIR), 8'hFF);
        rd(ra(6, `PIO_OFF_DATA), 8'h01);
        wr(9'h0E0, 8'hFF);
        rd(9'h0E0, 8'h00);
        wr(`PIO_ADDR_AUX, 8'h03);
        rd(`PIO_ADDR_AUX, 8'h07);
        look();
        cmp_pin(out_only_pin_o, 64'h3);
        $display("test ports done");
        close_out();
    end
endmodule
